// ### dsic_pkg.sv
// Purpose: Shared constants and carriers for the serial converter front end
// Assumes: 16-bit words, MSB first
// Notes:   Strap levels are sampled by the core clock
package dsic_pkg;
    localparam int          WORD_W        = 16;
    localparam int          CNT_W         = 5;
    localparam logic [15:0] RESET_LOW_VAL = 16'h0000;
    localparam logic [15:0] RESET_HIGH_VAL = 16'h8000;
    localparam logic [15:0] MSB_FLIP      = 16'h8000;
    localparam logic [4:0]  FRAME_BITS    = 5'h10;
    localparam int          BUF_DEPTH     = 2;

    typedef struct packed {
        logic format_select;
        logic reset_level_select;
        logic serial_out_select;
    } dsic_straps_t;

    typedef struct packed {
        logic [15:0] word;
    } dsic_word_t;
endpackage : dsic_pkg

// ### dsic_buf2.sv
// Purpose: Two-entry valid/ready buffer for captured frame words
// Assumes: Single clock domain
// Notes:   Depth is a parameter; full and empty are exact
module dsic_buf2 #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = push ? bump(wr_reg) : wr_reg;
        rd_next  = pop ? bump(rd_reg) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule : dsic_buf2

// ### dsic_core.sv
// Purpose: Serial input, input register and output latch of a 16-bit converter
// Assumes: Link pins are asynchronous and sampled by sys_clk (SCLK well below sys_clk/4)
// Notes:   Link edges are seen two to three cycles late; rst is power-on reset
// Summary of operation
// R1 - Format strap high means straight binary, low means two's complement.
// R2 - Binary: FFFF full scale minus one, 8000 mid, 0000 zero.
// R3 - Two's complement: 7FFF top, 0000 mid, 8000 zero; flip the MSB.
// R4 - Power-down pin grounds output, stored words stay unchanged.
// R5 - Serial shifting continues during power-down.
// R6 - Reset pin low forces both registers to strap-selected reset value.
// R7 - Power-up loads both registers with strap-selected reset value.
// R8 - Reset value 0000 with strap low, 8000 with strap high.
// R9 - Chip select low frames the transfer; bits taken only then.
// R10 - DIN shifted into 16-bit register on each rising SCLK while selected.
// R11 - Frames under 16 bits are discarded, registers keep old data. Code: a short frame during a buffer stall shifts into the pending word.
// R12 - Longer frames keep only the last 16 bits.
// R13 - Rising chip select after a valid frame copies shift register to input.
// R14 - Host lowers select before first clock, raises after sixteenth.
// R15 - Load strobe low updates the output latch from the input register.
// R16 - Standalone mode shifts input register out on SDO during the frame.
// R17 - Standalone: after 16 bits SDO gives zeros; last 16 inputs kept.
// R18 - Host ignores standalone readback from frames shorter than 16 bits.
// R19 - Daisy-chain mode: bits beyond the sixteenth ripple out on SDO.
// R20 - SDO changes on falling SCLK, sampled on the next rising edge.
// R21 - Host sends exactly 16 times N clocks for a chain of N.
// R22 - Strobe high holds latch; strobe low makes latch follow input register.
// R23 - Words travel most significant bit first.
module dsic_core (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Serial link pins
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 din,
    output logic                      sdo,
    // Control pins and straps
    input  wire logic                 reset_n,
    input  wire logic                 load_output_n,
    input  wire logic                 powerdown_pin,
    input  wire dsic_pkg::dsic_straps_t straps,
    // Converter side
    output logic [15:0]               dac_code,
    output logic                      analog_output_enable,
    output logic                      output_ground,
    output logic [15:0]               input_word,
    output logic                      frame_error
);
    // Synchronisers: first stage feeds only the second
    logic [5:0] s1_reg, s2_reg;
    logic       sclk_d_reg, cs_d_reg;
    logic       sclk_s, cs_s, din_s, rstp_s, ld_s, pd_s;
    dsic_pkg::dsic_straps_t strap_s;
    logic [2:0] st1_reg, st2_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Idle pin levels, so no false link edge or power-down blip follows reset
            s1_reg     <= 6'h32;
            s2_reg     <= 6'h32;
            st1_reg    <= 3'h0;
            st2_reg    <= 3'h0;
            sclk_d_reg <= 1'b0;
            cs_d_reg   <= 1'b1;
        end else begin
            s1_reg     <= {reset_n, load_output_n, powerdown_pin, din, cs_n, sclk};
            s2_reg     <= s1_reg;
            st1_reg    <= straps;
            st2_reg    <= st1_reg;
            sclk_d_reg <= s2_reg[0];
            cs_d_reg   <= s2_reg[1];
        end
    end

    assign sclk_s  = s2_reg[0];
    assign cs_s    = s2_reg[1];
    assign din_s   = s2_reg[2];
    assign pd_s    = s2_reg[3];
    assign ld_s    = s2_reg[4];
    assign rstp_s  = s2_reg[5];
    assign strap_s = st2_reg;

    logic sclk_rise, sclk_fall, cs_rise, cs_fall, selected;
    assign selected  = !cs_s;                                 // R9
    assign sclk_rise = sclk_s && !sclk_d_reg;
    assign sclk_fall = !sclk_s && sclk_d_reg;
    assign cs_rise   = cs_s && !cs_d_reg;
    assign cs_fall   = !cs_s && cs_d_reg;

    function automatic logic [15:0] reset_value(input logic level);
        reset_value = level ? dsic_pkg::RESET_HIGH_VAL : dsic_pkg::RESET_LOW_VAL; // R8
    endfunction : reset_value

    // Link-side state
    logic [15:0] shift_reg, shift_next;
    logic [15:0] rb_reg, rb_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic        sdo_reg, sdo_next;
    logic        pend_reg, pend_next;
    logic        ferr_reg, ferr_next;
    logic        push;
    logic        buf_ready;
    logic        buf_valid;
    logic [15:0] buf_data;
    logic        hw_reset;
    logic [15:0] in_reg, in_next;
    logic [15:0] latch_reg, latch_next;

    assign hw_reset = !rstp_s;

    always_comb begin
        shift_next = shift_reg;
        rb_next    = rb_reg;
        cnt_next   = cnt_reg;
        sdo_next   = sdo_reg;
        pend_next  = pend_reg;
        ferr_next  = 1'b0;
        push       = 1'b0;
        if (cs_fall) begin
            cnt_next = '0;
            rb_next  = in_reg;
            sdo_next = strap_s.serial_out_select ? in_reg[15] : shift_reg[15];
        end else if (selected && sclk_rise) begin
            shift_next = {shift_reg[14:0], din_s};            // R10 R12 R23 R5
            if (cnt_reg != dsic_pkg::FRAME_BITS) begin
                cnt_next = cnt_reg + 5'h01;
            end
        end else if (selected && sclk_fall) begin
            // R20
            rb_next = {rb_reg[14:0], 1'b0};                   // R17
            if (strap_s.serial_out_select) begin
                sdo_next = rb_reg[14];                        // R16
            end else begin
                sdo_next = shift_reg[15];                     // R19
            end
        end
        if (cs_rise) begin
            if (cnt_reg == dsic_pkg::FRAME_BITS) begin
                pend_next = 1'b1;                             // R13
            end else begin
                ferr_next = 1'b1;                             // R11
            end
        end
        // Word waits if the buffer is full; it is taken from shift_reg at the push, so any new frame during the stall, short or not, shifts into it
        if (pend_reg && buf_ready) begin
            push      = 1'b1;
            pend_next = cs_rise && (cnt_reg == dsic_pkg::FRAME_BITS);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= 16'h0000;
            rb_reg    <= 16'h0000;
            cnt_reg   <= 5'h00;
            sdo_reg   <= 1'b0;
            pend_reg  <= 1'b0;
            ferr_reg  <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            rb_reg    <= rb_next;
            cnt_reg   <= cnt_next;
            sdo_reg   <= sdo_next;
            pend_reg  <= pend_next;
            ferr_reg  <= ferr_next;
        end
    end

    dsic_buf2 #(
        .W     (dsic_pkg::WORD_W),
        .DEPTH (dsic_pkg::BUF_DEPTH)
    ) u_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (shift_reg),
        .out_valid (buf_valid),
        .out_ready (!hw_reset),
        .out_data  (buf_data)
    );

    // Input register and output latch
    logic init_reg;
    always_comb begin
        in_next    = in_reg;
        latch_next = latch_reg;
        if (init_reg || hw_reset) begin
            in_next    = reset_value(strap_s.reset_level_select); // R6 R7
            latch_next = reset_value(strap_s.reset_level_select); // R6 R7
        end else begin
            if (buf_valid) begin
                in_next = buf_data;
            end
            if (!ld_s) begin
                latch_next = in_reg;                          // R15 R22
            end
        end
    end

    // Power-up value taken from the straps once they have settled
    logic [1:0] init_cnt_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_reg       <= 16'h0000;
            latch_reg    <= 16'h0000;
            init_cnt_reg <= 2'h0;
            init_reg     <= 1'b1;
        end else begin
            in_reg       <= in_next;
            latch_reg    <= latch_next;
            init_cnt_reg <= (init_cnt_reg == 2'h3) ? init_cnt_reg : init_cnt_reg + 2'h1;
            init_reg     <= (init_cnt_reg != 2'h3);
        end
    end

    // Output code: the ladder wants offset binary
    logic [15:0] code_reg;
    logic        pd_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            code_reg <= 16'h0000;
            pd_reg   <= 1'b0;
        end else begin
            code_reg <= strap_s.format_select ? latch_reg : (latch_reg ^ dsic_pkg::MSB_FLIP); // R1 R2 R3
            pd_reg   <= pd_s;                                 // R4
        end
    end

    assign dac_code             = code_reg;
    assign output_ground        = pd_reg;
    assign analog_output_enable = !pd_reg;
    assign input_word           = in_reg;
    assign sdo                  = sdo_reg;
    assign frame_error          = ferr_reg;

    // Checks
    property p_short_frame;
        @(posedge sys_clk) disable iff (rst)
        (cs_rise && cnt_reg < dsic_pkg::FRAME_BITS && !pend_reg && !buf_valid) |=> !push && !pend_reg;
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame accepted"); // R11

    property p_valid_frame;
        @(posedge sys_clk) disable iff (rst)
        (cs_rise && cnt_reg == dsic_pkg::FRAME_BITS) |=> pend_reg;
    endproperty
    a_valid_frame: assert property (p_valid_frame) else $error("valid frame not captured"); // R13

    property p_shift;
        @(posedge sys_clk) disable iff (rst)
        (selected && sclk_rise && !cs_fall) |=> shift_reg == {$past(shift_reg[14:0]), $past(din_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // R10

    property p_hold_latch;
        @(posedge sys_clk) disable iff (rst)
        (ld_s && !hw_reset && !init_reg) |=> $stable(latch_reg);
    endproperty
    a_hold_latch: assert property (p_hold_latch) else $error("latch moved while held"); // R22

    property p_transparent;
        @(posedge sys_clk) disable iff (rst)
        (!ld_s && !hw_reset && !init_reg) |=> latch_reg == $past(in_reg);
    endproperty
    a_transparent: assert property (p_transparent) else $error("latch not following"); // R15

    property p_hw_reset;
        @(posedge sys_clk) disable iff (rst)
        hw_reset |=> in_reg == reset_value($past(strap_s.reset_level_select));
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("reset value wrong"); // R6

    property p_format;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> dac_code == ($past(strap_s.format_select) ? $past(latch_reg) : ($past(latch_reg) ^ dsic_pkg::MSB_FLIP));
    endproperty
    a_format: assert property (p_format) else $error("format mapping wrong"); // R1

    property p_powerdown;
        @(posedge sys_clk) disable iff (rst)
        pd_s |=> output_ground && !analog_output_enable;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("power-down not applied"); // R4

    property p_sdo_fall;
        @(posedge sys_clk) disable iff (rst)
        (!sclk_fall && !cs_fall) |=> $stable(sdo_reg);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved off falling edge"); // R20

    property p_deselected;
        @(posedge sys_clk) disable iff (rst)
        !selected |=> $stable(shift_reg) && $stable(cnt_reg);
    endproperty
    a_deselected: assert property (p_deselected) else $error("shift while deselected"); // R9

    property p_readback_zero;
        @(posedge sys_clk) disable iff (rst)
        (selected && sclk_fall && !cs_fall && strap_s.serial_out_select && cnt_reg == dsic_pkg::FRAME_BITS) |=> !sdo_reg;
    endproperty
    a_readback_zero: assert property (p_readback_zero) else $error("readback not zero after sixteen bits"); // R17

    c_valid:  cover property (@(posedge sys_clk) disable iff (rst) cs_rise && cnt_reg == dsic_pkg::FRAME_BITS);
    c_short:  cover property (@(posedge sys_clk) disable iff (rst) ferr_reg);
    c_full:   cover property (@(posedge sys_clk) disable iff (rst) pend_reg && !buf_ready);
    c_pdshift: cover property (@(posedge sys_clk) disable iff (rst) pd_s && selected && sclk_rise);
    c_daisy:  cover property (@(posedge sys_clk) disable iff (rst) selected && sclk_fall && !strap_s.serial_out_select && cnt_reg == dsic_pkg::FRAME_BITS);
endmodule : dsic_core

// ### dsic_host.sv
// Purpose: Host-side link master model driving frames into the converter front end
// Assumes: Link clock of 160 ns, idle low, standing still between frames
// Notes:   Data pin shows the inverse of its last value while deselected
module dsic_host (
    // Clock
    input  wire logic sys_clk,
    // Link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 16;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Sends the low nbits of data, first bit from the top; rx gathers the readback
    task automatic send_frame(input logic [31:0] data, input int nbits, output logic [31:0] rx);
        rx = 32'h00000000;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        din  <= data[nbits-1];
        repeat (HALF) @(posedge sys_clk);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            din  <= data[i];
            repeat (HALF) @(posedge sys_clk);
            // Read back just before the rising edge, well after the falling-edge update
            rx = {rx[30:0], sdo};
            sclk <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
        end
        sclk <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
        cs_n <= 1'b1;
        din  <= ~din;
        repeat (HALF) @(posedge sys_clk);
    endtask : send_frame

    // Clock pulses with the link deselected; the device must not take them
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            sclk <= 1'b1;
            din  <= ~din;
            repeat (HALF) @(posedge sys_clk);
            sclk <= 1'b0;
            repeat (HALF) @(posedge sys_clk);
        end
    endtask : stray_clocks
endmodule : dsic_host

// ### dsic_core_test.sv
// Purpose: Self-checking bench for the serial converter front end
// Assumes: Latencies as handed over; waits of ten cycles cover them
// Notes:   Ordinary codes run from a table, awkward cases follow by hand
module dsic_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic        fmt;
        logic [15:0] word;
        logic [15:0] dac;
    } dsic_row_t;

    logic                  sys_clk;
    logic                  rst;
    logic                  sclk;
    logic                  cs_n;
    logic                  din;
    logic                  sdo;
    logic                  reset_n;
    logic                  load_output_n;
    logic                  powerdown_pin;
    dsic_pkg::dsic_straps_t straps;
    logic [15:0]           dac_code;
    logic                  analog_output_enable;
    logic                  output_ground;
    logic [15:0]           input_word;
    logic                  frame_error;
    logic [31:0]           rx;
    logic [15:0]           prev;
    int                    err_count = 0;
    int                    samples_checked = 0;
    int                    fe_count = 0;
    int                    fe0;
    dsic_row_t             rows [7] = '{
        '{1'b1, 16'hFFFF, 16'hFFFF}, '{1'b1, 16'h8000, 16'h8000}, '{1'b1, 16'h0000, 16'h0000},
        '{1'b0, 16'h7FFF, 16'hFFFF}, '{1'b0, 16'h0000, 16'h8000}, '{1'b0, 16'hFFFF, 16'h7FFF},
        '{1'b0, 16'h8000, 16'h0000}};

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    dsic_core dut (
        .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo),
        .reset_n(reset_n), .load_output_n(load_output_n), .powerdown_pin(powerdown_pin),
        .straps(straps), .dac_code(dac_code), .analog_output_enable(analog_output_enable),
        .output_ground(output_ground), .input_word(input_word), .frame_error(frame_error)
    );

    dsic_host u_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo));

    always @(posedge sys_clk) begin
        if (frame_error === 1'b1) begin
            fe_count <= fe_count + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic settle;
        repeat (10) @(posedge sys_clk);
    endtask : settle

    task automatic frame16(input logic [15:0] w);
        u_host.send_frame({16'h0000, w}, 16, rx);
        settle();
    endtask : frame16

    // Far longer than the whole sequence needs
    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        reset_n = 1'b1;
        load_output_n = 1'b0;
        powerdown_pin = 1'b0;
        straps.format_select = 1'b1;
        straps.reset_level_select = 1'b1;
        straps.serial_out_select = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check(input_word, 16'h8000);
        check(dac_code, 16'h8000);
        prev = 16'h8000;
        foreach (rows[i]) begin
            straps.format_select <= rows[i].fmt;
            settle();
            frame16(rows[i].word);
            check(input_word, rows[i].word);
            check(dac_code, rows[i].dac);
            check(rx[15:0], prev);
            prev = rows[i].word;
        end
        straps.format_select <= 1'b1;
        settle();
        // Short frame is dropped; its readback is ignored
        fe0 = fe_count;
        u_host.send_frame(32'h000000A5, 8, rx);
        settle();
        check(input_word, 16'h8000);
        check(16'(fe_count - fe0), 16'h0001);
        // Twenty clocks in standalone mode
        u_host.send_frame(32'h0009ABCD, 20, rx);
        settle();
        check(rx[19:4], 16'h8000);
        check({12'h000, rx[3:0]}, 16'h0000);
        check(input_word, 16'hABCD);
        // Two-device chain: 32 clocks
        straps.serial_out_select <= 1'b0;
        settle();
        u_host.send_frame(32'h13572468, 32, rx);
        settle();
        check(rx[15:0], 16'h1357);
        check(input_word, 16'h2468);
        // Clocks while deselected must leave the shift register alone
        u_host.stray_clocks(8);
        settle();
        check(input_word, 16'h2468);
        // Strobe high holds the latch
        load_output_n <= 1'b1;
        frame16(16'h4321);
        check(rx[15:0], 16'h2468);
        check(input_word, 16'h4321);
        check(dac_code, 16'h2468);
        load_output_n <= 1'b0;
        settle();
        check(dac_code, 16'h4321);
        // Power-down keeps stored words and the link alive
        load_output_n <= 1'b1;
        powerdown_pin <= 1'b1;
        settle();
        check({15'h0000, output_ground}, 16'h0001);
        check({15'h0000, analog_output_enable}, 16'h0000);
        frame16(16'h0F0F);
        check(input_word, 16'h0F0F);
        check(dac_code, 16'h4321);
        powerdown_pin <= 1'b0;
        load_output_n <= 1'b0;
        settle();
        check(dac_code, 16'h0F0F);
        check({15'h0000, analog_output_enable}, 16'h0001);
        // Hardware reset with the strap low
        straps.reset_level_select <= 1'b0;
        settle();
        reset_n <= 1'b0;
        settle();
        check(input_word, 16'h0000);
        check(dac_code, 16'h0000);
        reset_n <= 1'b1;
        settle();
        frame16(16'hBEEF);
        check(input_word, 16'hBEEF);
        check(dac_code, 16'hBEEF);
        finish_test();
    end
endmodule : dsic_core_test
